/* include/pcg_pkg.sv */
// Package: register map, field positions and reset values of the PWM / contrast pulse block
package pcg_pkg;
  // Printed offsets are not multiples of four: offsets are register indices
  localparam logic [7:0] IDX_CONTROL = 8'hb0;
  localparam logic [7:0] IDX_CONFIG = 8'hb1;
  localparam logic [7:0] IDX_BURST_LEN = 8'hb2;
  localparam logic [7:0] IDX_DUTY = 8'hb3;
  localparam logic [7:0] IDX_POWER = 8'hc0;
  localparam logic [11:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_CONFIG = {2'h0, IDX_CONFIG, 2'h0};
  localparam logic [11:0] ADDR_BURST_LEN = {2'h0, IDX_BURST_LEN, 2'h0};
  localparam logic [11:0] ADDR_DUTY = {2'h0, IDX_DUTY, 2'h0};
  localparam logic [11:0] ADDR_POWER = {2'h0, IDX_POWER, 2'h0};
  localparam int CTL_PWM_FORCE_HIGH = 7;
  localparam int CTL_PWM_ENABLE = 4;
  localparam int CTL_CP_FORCE_HIGH = 3;
  localparam int CTL_BURST_STATUS = 2;
  localparam int CTL_BURST_START = 1;
  localparam int CTL_CP_ENABLE = 0;
  localparam int CFG_PWM_DIV_LSB = 4;
  localparam int CFG_CP_DIV_LSB = 1;
  localparam int CFG_SRC_SEL = 0;
  localparam int PWR_SAVE = 0;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_BURST_LEN = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic RST_POWER_SAVE = 1'b1;
  localparam logic [3:0] PWM_DIV_MAX = 4'hc;
  localparam int PRESCALE_W = 12;
endpackage : pcg_pkg

/* rtl/pcg_prescaler.sv */
// Power-of-two prescaler producing a one-cycle enable from a source enable
`timescale 1ns/1ps
module pcg_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic src_tick,
  input wire logic [3:0] div_sel,
  output logic tick
);
  import pcg_pkg::*;

  logic [PRESCALE_W-1:0] count;
  logic [PRESCALE_W-1:0] limit;

  // Divide by 2 to the power div_sel
  assign limit = PRESCALE_W'((13'h1 << div_sel) - 13'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (src_tick) begin
      if (count >= limit) begin
        count <= '0;
      end else begin
        count <= count + 12'h1;
      end
    end
  end

  assign tick = run && src_tick && (count >= limit);
endmodule : pcg_prescaler

/* rtl/pcg_pulse_gen.sv */
// PWM clock and contrast pulse burst generator with APB register access
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - PWM pin: generator when enabled, low when off, high when forced.
// - Contrast pin: generator when enabled, low when off, high when forced.
// - Power save stops the PWM circuitry.
// - Power save stops the contrast pulse circuitry.
// - Burst status reads 1 while a burst runs, else 0.
// - Writing start 1 launches one burst, only while contrast enable is 1.
// - Burst pulses run at prescaled contrast source over 2, 50/50 duty.
// - Burst holds burst length plus one pulses, 1 to 256.
// - PWM prescale divides by 2 to the field, up to 4096.
// - Prescaled PWM clock divided by fixed 256 forms the period.
// - Contrast prescale divides by 2 to the field, up to 128.
// - Source select picks primary clock at 0, secondary at 1.
// - Duty 0 holds PWM low; N gives N of 256 periods high.
// - Power save enable is 1 after reset.
module pcg_pulse_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primary_input_clock,
  input wire logic secondary_input_clock,
  output logic pwm_output_pin,
  output logic contrast_pulse_output_pin
);
  import pcg_pkg::*;

  typedef enum logic [0:0] {
    PCG_IDLE = 1'b0,
    PCG_BURST = 1'b1
  } pcg_burst_t;

  logic [7:0] control;
  logic [7:0] config_reg;
  logic [7:0] burst_len;
  logic [7:0] duty;
  logic power_save;
  pcg_burst_t burst_state;
  logic [8:0] pulses_left;
  logic cp_phase;
  logic [7:0] pwm_count;
  logic pwm_level;
  logic [1:0] pri_sync;
  logic [1:0] sec_sync;
  logic src_prev;
  logic src_tick;
  logic src_level;
  logic pwm_run;
  logic cp_run;
  logic pwm_tick;
  logic cp_tick;
  logic wr_en;
  logic rd_en;
  logic start_req;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [3:0] pwm_div;
  logic [3:0] cp_div;
  logic [8:0] burst_total;
  logic burst_active;
  logic burst_abort;
  logic pulse_end;

  function automatic logic addr_known(input logic [11:0] a);
    return (a == ADDR_CONTROL) || (a == ADDR_CONFIG) || (a == ADDR_BURST_LEN) ||
           (a == ADDR_DUTY) || (a == ADDR_POWER);
  endfunction : addr_known

  // One-wait-state APB: answer on the second access cycle
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && !pready;

  // pready lasts one cycle, so a held access is answered again every second cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_comb begin
    next_prdata = 32'h0;
    next_slverr = !addr_known(paddr);
    if (paddr == ADDR_CONTROL) begin
      next_prdata[7:0] = {control[7:3], burst_state == PCG_BURST, control[1:0]};
    end else if (paddr == ADDR_CONFIG) begin
      next_prdata[7:0] = config_reg;
    end else if (paddr == ADDR_BURST_LEN) begin
      next_prdata[7:0] = burst_len;
    end else if (paddr == ADDR_DUTY) begin
      next_prdata[7:0] = duty;
    end else if (paddr == ADDR_POWER) begin
      next_prdata[PWR_SAVE] = power_save;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (rd_en) begin
      prdata <= next_prdata;
      pslverr <= next_slverr;
    end else if (psel && penable && pwrite && !pready) begin
      pslverr <= next_slverr;
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= RST_CONTROL;
      config_reg <= RST_CONFIG;
      burst_len <= RST_BURST_LEN;
      duty <= RST_DUTY;
    end else if (wr_en && pstrb[0]) begin
      if (paddr == ADDR_CONTROL) begin
        control <= {pwdata[7:3], 1'b0, pwdata[1:0]};
      end else if (paddr == ADDR_CONFIG) begin
        config_reg <= pwdata[7:0];
      end else if (paddr == ADDR_BURST_LEN) begin
        burst_len <= pwdata[7:0];
      end else if (paddr == ADDR_DUTY) begin
        duty <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_save <= RST_POWER_SAVE;
    end else if (wr_en && pstrb[0] && paddr == ADDR_POWER) begin
      power_save <= pwdata[PWR_SAVE];
    end
  end

  // Source clocks come from pins: two-flop synchronisers
  // Sources must stay below half of pclk or their edges are missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_sync <= 2'h0;
      sec_sync <= 2'h0;
      src_prev <= 1'b0;
    end else begin
      pri_sync <= {pri_sync[0], primary_input_clock};
      sec_sync <= {sec_sync[0], secondary_input_clock};
      src_prev <= src_level;
    end
  end

  assign src_level = config_reg[CFG_SRC_SEL] ? sec_sync[1] : pri_sync[1];
  assign src_tick = src_level && !src_prev;

  assign pwm_run = !power_save && control[CTL_PWM_ENABLE] && !control[CTL_PWM_FORCE_HIGH];
  assign cp_run = !power_save && burst_active;

  // Reserved divide codes act as the largest, 4096
  assign pwm_div = (config_reg[CFG_PWM_DIV_LSB +: 4] > PWM_DIV_MAX) ? PWM_DIV_MAX :
                   config_reg[CFG_PWM_DIV_LSB +: 4];
  // Three-bit contrast code, widened for the shared prescaler
  assign cp_div = {1'b0, config_reg[CFG_CP_DIV_LSB +: 3]};

  pcg_prescaler u_pwm_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(pwm_run),
    .src_tick(src_tick),
    .div_sel(pwm_div),
    .tick(pwm_tick)
  );

  pcg_prescaler u_cp_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(cp_run),
    .src_tick(src_tick),
    .div_sel(cp_div),
    .tick(cp_tick)
  );

  // Fixed divide by 256 period counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_count <= 8'h00;
    end else if (!pwm_run) begin
      pwm_count <= 8'h00;
    end else if (pwm_tick) begin
      pwm_count <= pwm_count + 8'h01;
    end
  end

  // High for duty of 256 periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_level <= 1'b0;
    end else begin
      pwm_level <= pwm_run && (pwm_count < duty);
    end
  end

  // Start only while contrast enable is 1
  assign start_req = wr_en && pstrb[0] && paddr == ADDR_CONTROL &&
                     pwdata[CTL_BURST_START] && pwdata[CTL_CP_ENABLE] &&
                     !pwdata[CTL_CP_FORCE_HIGH] && !power_save;

  // Burst in progress: status bit and contrast prescaler run
  assign burst_active = (burst_state == PCG_BURST);
  assign burst_total = {1'b0, burst_len} + 9'h001;
  // Clearing enable, setting force or entering power save cuts a burst short
  assign burst_abort = power_save || !control[CTL_CP_ENABLE] ||
                       control[CTL_CP_FORCE_HIGH];
  // Falling edge of the last pulse ends the burst, output low
  assign pulse_end = cp_tick && cp_phase && (pulses_left == 9'h001);

  // Burst state behind the status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_state <= PCG_IDLE;
    end else begin
      case (burst_state)
        PCG_IDLE: begin
          if (start_req) begin
            burst_state <= PCG_BURST;
          end
        end
        PCG_BURST: begin
          if (burst_abort || pulse_end) begin
            burst_state <= PCG_IDLE;
          end
        end
        default: begin
          burst_state <= PCG_IDLE;
        end
      endcase
    end
  end

  // Pulses still to send, loaded at start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulses_left <= 9'h000;
    end else if (!burst_active && start_req) begin
      pulses_left <= burst_total;
    end else if (burst_active && !burst_abort && cp_tick && cp_phase) begin
      pulses_left <= pulses_left - 9'h001;
    end
  end

  // Toggle per prescaled tick gives divide by 2 at 50/50
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_phase <= 1'b0;
    end else if (!burst_active || burst_abort) begin
      cp_phase <= 1'b0;
    end else if (cp_tick) begin
      cp_phase <= !cp_phase;
    end
  end

  // PWM pin: forced high, generator or low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_output_pin <= 1'b0;
    end else begin
      pwm_output_pin <= control[CTL_PWM_FORCE_HIGH] ||
                        (control[CTL_PWM_ENABLE] && pwm_level);
    end
  end

  // Contrast pin: forced high, burst pulses or low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contrast_pulse_output_pin <= 1'b0;
    end else begin
      contrast_pulse_output_pin <= control[CTL_CP_FORCE_HIGH] ||
                                   (control[CTL_CP_ENABLE] && cp_phase && burst_active);
    end
  end
endmodule : pcg_pulse_gen

/* verif/pcg_pulse_gen_props.sv */
// Checker: port-level properties of the pulse generator
`timescale 1ns/1ps
module pcg_pulse_gen_props
  import pcg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_output_pin,
  input wire logic contrast_pulse_output_pin
);
  logic wc;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed control write
  assign wc = psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_CONTROL;
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  a_ready_access: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not in second access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_pwm_force_high: assert property (
    wc && pwdata[CTL_PWM_FORCE_HIGH] |-> ##[1:2] pwm_output_pin)
    else $error("pwm pin not forced high");
  a_pwm_force_low: assert property (
    wc && !pwdata[CTL_PWM_FORCE_HIGH] && !pwdata[CTL_PWM_ENABLE] |-> ##[1:2] !pwm_output_pin)
    else $error("pwm pin not forced low");
  a_cp_force_high: assert property (
    wc && pwdata[CTL_CP_FORCE_HIGH] |-> ##[1:2] contrast_pulse_output_pin)
    else $error("contrast pin not forced high");
  a_cp_force_low: assert property (
    wc && !pwdata[CTL_CP_FORCE_HIGH] && !pwdata[CTL_CP_ENABLE] |-> ##[1:2] !contrast_pulse_output_pin)
    else $error("contrast pin not forced low");
endmodule : pcg_pulse_gen_props

bind pcg_pulse_gen pcg_pulse_gen_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_output_pin(pwm_output_pin),
  .contrast_pulse_output_pin(contrast_pulse_output_pin));

/* verif/pcg_panel_model.sv */
// Panel side model: source clocks and contrast pulse monitor
`timescale 1ns/1ps
module pcg_panel_model (
  output logic primary_input_clock,
  output logic secondary_input_clock,
  input wire logic contrast_pulse_output_pin
);
  int n_rise = 0;
  time t_r = 0;
  time t_f = 0;
  time hi_w = 0;
  time lo_w = 0;
  // Sources run free at 8 and 12 bus clock periods, toggling on bus clock falling edges
  initial begin
    primary_input_clock = 1'b0;
    secondary_input_clock = 1'b0;
  end
  always #160 primary_input_clock = ~primary_input_clock;
  always #240 secondary_input_clock = ~secondary_input_clock;
  always @(posedge contrast_pulse_output_pin) begin
    n_rise++;
    lo_w = $time - t_f;
    t_r = $time;
  end
  always @(negedge contrast_pulse_output_pin) begin
    hi_w = $time - t_r;
    t_f = $time;
  end
endmodule : pcg_panel_model

/* verif/pcg_pulse_gen_tb.sv */
// Testbench: register access, PWM duty and contrast bursts
`timescale 1ns/1ps
module pcg_pulse_gen_tb;
  import pcg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, pri_clk, sec_clk, pwm_pin, cp_pin;
  int n_fail = 0, num_checks = 0;
  always #20 pclk = ~pclk;
  pcg_pulse_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .primary_input_clock(pri_clk),
    .secondary_input_clock(sec_clk), .pwm_output_pin(pwm_pin),
    .contrast_pulse_output_pin(cp_pin));
  pcg_panel_model mdl (.primary_input_clock(pri_clk), .secondary_input_clock(sec_clk),
    .contrast_pulse_output_pin(cp_pin));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : apb
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask : rd
  task hcnt(input int n, output int c);
    c = 0;
    repeat (n) @(posedge pclk) c += int'(pwm_pin);
  endtask : hcnt
  task pwm(input logic [7:0] cfg, input logic [7:0] duty, input int per, input int x);
    int c;
    wr(ADDR_CONFIG, cfg);
    wr(ADDR_DUTY, duty);
    repeat (per) @(posedge pclk);
    hcnt(per, c);
    chk(c, x);
  endtask : pwm
  task burst(input logic [7:0] cfg, input logic [7:0] len, output time hw);
    int n0;
    int i;
    logic [31:0] r;
    logic e;
    wr(ADDR_CONFIG, cfg);
    wr(ADDR_BURST_LEN, len);
    wr(ADDR_CONTROL, 8'h01);
    n0 = mdl.n_rise;
    wr(ADDR_CONTROL, 8'h03);
    rd(ADDR_CONTROL, 32'h07);
    i = 0;
    do begin
      apb(1'b0, ADDR_CONTROL, 32'h0, r, e);
      i++;
    end while (r[CTL_BURST_STATUS] !== 1'b0 && i < 3000);
    chk(i < 3000, 1);
    if (i >= 3000) tally_and_finish();
    chk(mdl.n_rise - n0, len + 1);
    chk(32'(mdl.hi_w), 32'(mdl.lo_w));
    chk(cp_pin, 0);
    hw = mdl.hi_w;
    wr(ADDR_CONTROL, 8'h01);
  endtask : burst
  initial begin
    int c;
    int n0;
    time w0;
    time w3;
    logic [31:0] r;
    logic e;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_CONFIG, 32'h0);
    rd(ADDR_BURST_LEN, 32'h0);
    rd(ADDR_DUTY, 32'h0);
    rd(ADDR_POWER, 32'h1);
    chk({pwm_pin, cp_pin}, 0);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({r, e}, 1);
    wr(ADDR_CONFIG, 8'hfe);
    rd(ADDR_CONFIG, 32'hfe);
    $display("registers done");
    wr(ADDR_POWER, 8'h00);
    wr(ADDR_CONTROL, 8'h88);
    repeat (3) @(posedge pclk);
    chk({pwm_pin, cp_pin}, 3);
    wr(ADDR_CONTROL, 8'h00);
    repeat (3) @(posedge pclk);
    chk({pwm_pin, cp_pin}, 0);
    $display("force done");
    wr(ADDR_CONTROL, 8'h10);
    pwm(8'h00, 8'h40, 2048, 512);
    pwm(8'h00, 8'h00, 2048, 0);
    pwm(8'h00, 8'hff, 2048, 2040);
    pwm(8'h01, 8'h40, 3072, 768);
    pwm(8'h10, 8'h40, 4096, 1024);
    $display("pwm done");
    wr(ADDR_CONTROL, 8'h00);
    n0 = mdl.n_rise;
    wr(ADDR_CONTROL, 8'h02);
    repeat (100) @(posedge pclk);
    chk(mdl.n_rise - n0, 0);
    burst(8'h00, 8'h01, w0);
    burst(8'h06, 8'h01, w3);
    chk(32'(w3), 32'(8 * w0));
    burst(8'h00, 8'hff, w0);
    $display("burst done");
    wr(ADDR_DUTY, 8'h40);
    wr(ADDR_CONTROL, 8'h11);
    wr(ADDR_CONTROL, 8'h13);
    wr(ADDR_POWER, 8'h01);
    repeat (20) @(posedge pclk);
    n0 = mdl.n_rise;
    hcnt(2048, c);
    chk(c, 0);
    chk(mdl.n_rise - n0, 0);
    $display("power save done");
    tally_and_finish();
  end
endmodule : pcg_pulse_gen_tb
